// file: rtl/emb_pkg.sv
package emb_pkg;

  // power control register layout
  localparam int          POWER_CONTROL_REGISTER_W          = 8;
  localparam int          ALE_QUIET_BIT   = 5;
  localparam logic        ALE_QUIET_RESET = 1'b0;

  // internal program memory holds addresses below this limit
  localparam logic [15:0] INT_ROM_LIMIT   = 16'hC000;

  // oscillator periods per address latch slot, two slots per machine cycle
  localparam int          SLOT_PHASES     = 6;
  localparam int          PHASE_W         = 3;
  localparam logic [2:0]  LAST_PHASE      = 3'h5;

  // phases inside a slot (one oscillator period each)
  localparam logic [2:0]  ALE_HI_END      = 3'h1;  // latch pulse high in phases 0..1
  localparam logic [2:0]  ADDR_END        = 3'h2;  // address held on low port to phase 2
  localparam logic [2:0]  PROGRAM_FETCH_STROBE_N_LO_FIRST   = 3'h3;  // fetch strobe low in phases 3..5
  localparam logic [2:0]  STB_LO_FIRST    = 3'h1;  // data strobe low in phases 1..4
  localparam logic [2:0]  STB_LO_LAST     = 3'h4;

  // machine cycle kinds, one-hot
  typedef enum logic [3:0] {
    MC_RUN   = 4'h1,
    MC_DATA  = 4'h2,
    MC_IDLE  = 4'h4,
    MC_PDOWN = 4'h8
  } emb_mc_e;

  // requests from the core side
  typedef struct packed {
    logic        fetch_en;
    logic [15:0] pc;
    logic        xmove;
    logic        xwrite;
    logic [15:0] xaddr;
    logic [7:0]  wdata;
    logic        idle;
    logic        pdown;
  } emb_req_s;

  // external bus pins
  typedef struct packed {
    logic       ale;
    logic       program_fetch_strobe_n_n;
    logic       wr_n;
    logic       rd_n;
    logic [7:0] p0_out;
    logic [7:0] p0_oe;
    logic       p0_pullup_en;
    logic [7:0] p2_out;
    logic       p2_addr_en;
  } emb_pins_s;

  localparam emb_pins_s PINS_RESET = '{
    ale: 1'b0, program_fetch_strobe_n_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, p0_out: 8'h00,
    p0_oe: 8'h00, p0_pullup_en: 1'b0, p2_out: 8'h00, p2_addr_en: 1'b0};

endpackage : emb_pkg

// file: rtl/emb_slot_timer.sv
`timescale 1ns/1ps

module emb_slot_timer #(
  parameter int PHASES = emb_pkg::SLOT_PHASES
) (
  // clock and reset
  input  wire logic                         mclk_in,
  input  wire logic                         reset_n_in,
  // timing
  output logic [emb_pkg::PHASE_W-1:0]       phase_out,
  output logic                              slot_out,
  output logic                              mc_end_out
);

  localparam logic [emb_pkg::PHASE_W-1:0] LAST = emb_pkg::PHASE_W'(PHASES - 1);

  logic [emb_pkg::PHASE_W-1:0] next_phase;
  logic                        next_slot;
  logic                        next_mc_end;

  // phase counter wraps every slot; two slots make a machine cycle
  always_comb begin
    next_phase  = (phase_out == LAST) ? '0 : phase_out + 1'b1;
    next_slot   = (phase_out == LAST) ? ~slot_out : slot_out;
    next_mc_end = (next_phase == LAST) && next_slot;
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_out  <= '0;
      slot_out   <= 1'b0;
      mc_end_out <= 1'b0;
    end else begin
      phase_out  <= next_phase;
      slot_out   <= next_slot;
      mc_end_out <= next_mc_end;
    end
  end

endmodule : emb_slot_timer

// file: rtl/emb_bus.sv
// Functional notes
// - During data-pointer external accesses the high address byte is driven on the high port.
// - External program fetches pulse the fetch strobe low twice per machine cycle.
// - A data access machine cycle skips both fetch strobe pulses.
// - The fetch strobe stays high whenever no external fetch is under way.
// - The latch pulse comes every six oscillator periods, omitted in the data strobe slot.
// - Bit 5 of the power control register is the quiet enable, written by software.
// - The quiet enable clears on reset.
// - With quiet set and no exception the latch pulse is held low.
// - Data moves still produce the latch pulse while quiet is set.
// - With quiet set the latch pulse is high in idle and low in power-down.
// - Internal execution with quiet set still pulses beyond the internal memory size.
// - External execution always pulses normally whatever quiet says.
// - Access select high at reset fetches internally below 49152, low fetches all externally.
// - Access select is caught at reset and ignored afterwards; the far side must drive it.
// - The low port multiplexes address and data with pull-ups enabled for external accesses.
// - Data transfers use separate write and read strobes.
`timescale 1ns/1ps

module emb_bus (
  // clock and reset
  input  wire logic                    mclk_in,
  input  wire logic                    reset_n_in,
  // strap
  input  wire logic                    ext_access_select_in,
  // core side
  input  wire emb_pkg::emb_req_s       req_in,
  input  wire logic                    power_control_register_we_in,
  input  wire logic [7:0]              power_control_register_wdata_in,
  output logic [7:0]                   instr_out,
  output logic                         instr_valid_out,
  output logic [7:0]                   rdata_out,
  output logic                         xmove_done_out,
  output logic                         ale_quiet_enable_out,
  output logic                         ea_internal_out,
  // external bus
  input  wire logic [7:0]              p0_in,
  output emb_pkg::emb_pins_s           pins_out
);

  logic [emb_pkg::PHASE_W-1:0] phase;
  logic                        slot;
  logic                        mc_end;

  emb_slot_timer #(
    .PHASES     (emb_pkg::SLOT_PHASES)
  ) u_timer (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .phase_out  (phase),
    .slot_out   (slot),
    .mc_end_out (mc_end)
  );

  // true when the fetch address lies outside internal program memory
  function automatic logic beyond_rom(input logic [15:0] addr);
    return addr >= emb_pkg::INT_ROM_LIMIT;
  endfunction : beyond_rom

  // ---------------- strap capture and quiet enable
  logic in_reset;
  logic ea_int;
  logic quiet;
  logic next_in_reset;
  logic next_ea_int;
  logic next_quiet;

  // strap is sampled at the first edge after release, the async reset only loads constants
  always_comb begin
    next_in_reset = 1'b0;
    next_ea_int   = in_reset ? ext_access_select_in : ea_int;
    next_quiet    = power_control_register_we_in ? power_control_register_wdata_in[emb_pkg::ALE_QUIET_BIT] : quiet;
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      in_reset <= 1'b1;
      ea_int   <= 1'b1;
      quiet    <= emb_pkg::ALE_QUIET_RESET;
    end else begin
      in_reset <= next_in_reset;
      ea_int   <= next_ea_int;
      quiet    <= next_quiet;
    end
  end

  // ---------------- machine cycle sequencing
  emb_pkg::emb_mc_e mc;
  emb_pkg::emb_mc_e next_mc;

  // kind only changes on a machine cycle boundary so strobes never get cut short
  always_comb begin
    next_mc = mc;
    if (mc_end) begin
      if (req_in.pdown)      next_mc = emb_pkg::MC_PDOWN;
      else if (req_in.idle)  next_mc = emb_pkg::MC_IDLE;
      else if (req_in.xmove) next_mc = emb_pkg::MC_DATA;
      else                   next_mc = emb_pkg::MC_RUN;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mc <= emb_pkg::MC_RUN;
    end else begin
      mc <= next_mc;
    end
  end

  // ---------------- pin generation
  logic               ext_slot;
  logic               ale_force;
  logic               ale_win;
  emb_pkg::emb_pins_s next_pins;

  // external fetch when strapped external or the address is past internal memory
  assign ext_slot  = req_in.fetch_en && (!ea_int || beyond_rom(req_in.pc));
  assign ale_force = !ea_int || beyond_rom(req_in.pc);
  assign ale_win   = phase <= emb_pkg::ALE_HI_END;

  // pins are registered, so they follow the timer phase by one clock
  always_comb begin
    next_pins            = emb_pkg::PINS_RESET;
    next_pins.p2_out     = pins_out.p2_out;
    unique case (mc)
      emb_pkg::MC_RUN: begin
        next_pins.ale = ale_win && (!quiet || ale_force);
        if (ext_slot) begin
          next_pins.p2_out       = req_in.pc[15:8];
          next_pins.p2_addr_en   = 1'b1;
          next_pins.p0_pullup_en = 1'b1;
          if (phase <= emb_pkg::ADDR_END) begin
            next_pins.p0_out = req_in.pc[7:0];
            next_pins.p0_oe  = 8'hFF;
          end else begin
            next_pins.program_fetch_strobe_n_n = 1'b0;
          end
        end
      end
      emb_pkg::MC_DATA: begin
        next_pins.p2_out       = req_in.xaddr[15:8];
        next_pins.p2_addr_en   = 1'b1;
        next_pins.p0_pullup_en = 1'b1;
        if (!slot) begin
          next_pins.ale    = ale_win;
          next_pins.p0_out = req_in.xaddr[7:0];
          next_pins.p0_oe  = 8'hFF;
        end else begin
          // no latch pulse and no fetch strobe in the strobe slot
          if (req_in.xwrite) begin
            next_pins.p0_out = req_in.wdata;
            next_pins.p0_oe  = 8'hFF;
          end
          if (phase >= emb_pkg::STB_LO_FIRST && phase <= emb_pkg::STB_LO_LAST) begin
            next_pins.wr_n = !req_in.xwrite;
            next_pins.rd_n = req_in.xwrite;
          end
        end
      end
      emb_pkg::MC_IDLE: begin
        next_pins.ale = 1'b1;
      end
      emb_pkg::MC_PDOWN: begin
        next_pins.ale = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pins_out <= emb_pkg::PINS_RESET;
    end else begin
      pins_out <= next_pins;
    end
  end

  // ---------------- core side returns
  logic [7:0] next_instr;
  logic       next_instr_valid;
  logic [7:0] next_rdata;
  logic       next_done;
  logic       fetch_cap;
  logic       read_cap;

  // sample the low port at the last phase of each strobe slot, while the pins still show the strobe low
  assign fetch_cap = (mc == emb_pkg::MC_RUN) && ext_slot && (phase == emb_pkg::LAST_PHASE)
                     && !pins_out.program_fetch_strobe_n_n;
  assign read_cap  = (mc == emb_pkg::MC_DATA) && slot && !req_in.xwrite
                     && (phase == emb_pkg::LAST_PHASE) && !pins_out.rd_n;

  always_comb begin
    next_instr       = fetch_cap ? p0_in : instr_out;
    next_instr_valid = fetch_cap;
    next_rdata       = read_cap ? p0_in : rdata_out;
    next_done        = mc_end && (mc == emb_pkg::MC_DATA);
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      instr_out            <= 8'h00;
      instr_valid_out      <= 1'b0;
      rdata_out            <= 8'h00;
      xmove_done_out       <= 1'b0;
      ale_quiet_enable_out <= emb_pkg::ALE_QUIET_RESET;
      ea_internal_out      <= 1'b1;
    end else begin
      instr_out            <= next_instr;
      instr_valid_out      <= next_instr_valid;
      rdata_out            <= next_rdata;
      xmove_done_out       <= next_done;
      ale_quiet_enable_out <= next_quiet;
      ea_internal_out      <= next_ea_int;
    end
  end

  // ---------------- checks
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  program_fetch_strobe_n_fetch_low_a: assert property (
    (mc == emb_pkg::MC_RUN && ext_slot && phase == emb_pkg::PROGRAM_FETCH_STROBE_N_LO_FIRST
     && $stable(req_in) && !mc_end) |=> !pins_out.program_fetch_strobe_n_n)
    else $error("fetch strobe not low in external fetch window");

  program_fetch_strobe_n_data_skip_a: assert property (
    (mc == emb_pkg::MC_DATA && !mc_end) |=> pins_out.program_fetch_strobe_n_n)
    else $error("fetch strobe active during data cycle");

  program_fetch_strobe_n_quiet_high_a: assert property (
    !pins_out.program_fetch_strobe_n_n |-> $past(mc == emb_pkg::MC_RUN && ext_slot))
    else $error("fetch strobe low without external fetch");

  ale_period_a: assert property (
    (mc == emb_pkg::MC_RUN && !quiet && !power_control_register_we_in && phase == 3'h0 && slot == 1'b0)
    |=> pins_out.ale ##1 pins_out.ale ##1 !pins_out.ale)
    else $error("latch pulse shape wrong");

  ale_quiet_low_a: assert property (
    (mc == emb_pkg::MC_RUN && quiet && !ale_force && !mc_end) |=> !pins_out.ale)
    else $error("latch pulse while quiet");

  ale_data_pulse_a: assert property (
    (mc == emb_pkg::MC_DATA && !slot && phase == 3'h0) |=> pins_out.ale)
    else $error("no latch pulse for data move");

  ale_idle_a: assert property (
    (quiet && mc == emb_pkg::MC_IDLE && !mc_end) |=> pins_out.ale)
    else $error("latch pulse not high in idle");

  ale_pdown_a: assert property (
    (quiet && mc == emb_pkg::MC_PDOWN && !mc_end) |=> !pins_out.ale)
    else $error("latch pulse not low in power-down");

  ale_ext_a: assert property (
    (!ea_int && quiet && mc == emb_pkg::MC_RUN && phase == 3'h0) |=> pins_out.ale)
    else $error("latch pulse missing in external execution");

  ale_beyond_a: assert property (
    (ea_int && quiet && beyond_rom(req_in.pc) && mc == emb_pkg::MC_RUN && phase == 3'h1)
    |=> pins_out.ale)
    else $error("latch pulse missing beyond internal memory");

  data_high_addr_a: assert property (
    (mc == emb_pkg::MC_DATA && !mc_end)
    |=> pins_out.p2_addr_en && pins_out.p2_out == $past(req_in.xaddr[15:8]))
    else $error("high address byte wrong in data cycle");

  strobe_sel_a: assert property (
    (mc == emb_pkg::MC_DATA && slot && phase == 3'h2)
    |=> (pins_out.wr_n != pins_out.rd_n) && (pins_out.wr_n == !$past(req_in.xwrite)))
    else $error("wrong data strobe");

  strap_hold_a: assert property (
    !in_reset |=> $stable(ea_int))
    else $error("access select changed after reset");

  pullup_a: assert property (
    (pins_out.p0_oe != 8'h00) |-> pins_out.p0_pullup_en)
    else $error("low port driven without pull-ups");

endmodule : emb_bus

// file: sim/emb_ext_mem.sv
`timescale 1ns/1ps

// external program and data memory with its address latch
module emb_ext_mem (
  // clock
  input  wire logic               mclk_in,
  // pins of the bus block
  input  wire emb_pkg::emb_pins_s pins_in,
  // resolved low port level and last write seen
  output logic [7:0]              p0_level_out,
  output logic [15:0]             wr_addr_out,
  output logic [7:0]              wr_data_out
);
  logic [7:0]  lat_lo = 8'h00;
  logic [7:0]  last   = 8'h00;
  logic        wr_q   = 1'b1;
  logic [15:0] addr;
  logic [7:0]  mem_byte;
  logic        mem_drv;

  // contents follow the address so the bench can predict every byte
  assign addr     = {pins_in.p2_out, lat_lo};
  assign mem_byte = addr[7:0] ^ addr[15:8] ^ 8'h5A;
  assign mem_drv  = !pins_in.program_fetch_strobe_n_n || !pins_in.rd_n;

  // released bits take the memory byte while a strobe is low, else the pull-up, else toggle so a stale value never passes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pins_in.p0_oe[i]) p0_level_out[i] = pins_in.p0_out[i];
      else if (mem_drv) p0_level_out[i] = mem_byte[i];
      else if (pins_in.p0_pullup_en) p0_level_out[i] = 1'b1;
      else p0_level_out[i] = ~last[i];
    end
  end

  // latch is open while the latch pulse is high; writes taken at strobe end
  always @(posedge mclk_in) begin
    last <= p0_level_out;
    wr_q <= pins_in.wr_n;
    if (pins_in.ale) lat_lo <= p0_level_out;
    if (pins_in.wr_n && !wr_q) begin
      wr_addr_out <= addr;
      wr_data_out <= p0_level_out;
    end
  end
endmodule : emb_ext_mem

// file: sim/external_memory_bus_strobes_tb.sv
`timescale 1ns/1ps

module external_memory_bus_strobes_tb;
  logic               mclk_in    = 1'b0;
  logic               reset_n_in = 1'b0;
  logic               strap      = 1'b1;
  logic               power_control_register_we    = 1'b0;
  logic [7:0]         power_control_register_wdata = 8'h00;
  emb_pkg::emb_req_s  req        = '0;
  emb_pkg::emb_pins_s pins;
  logic [7:0]         instr, rdata, p0_level, wr_data;
  logic               instr_valid, xdone, quiet, ea_int;
  logic [15:0]        wr_addr;
  logic [15:0]        ale_rises, program_fetch_strobe_n_falls, rd_lows, wr_lows, ale_highs, valids;
  logic               ale_q     = 1'b0;
  logic               program_fetch_strobe_n_q    = 1'b1;
  logic [11:0]        program_fetch_strobe_n_hist = 12'hFFF;
  int                 miscompares = 0;
  int                 checks_done = 0;

  always #2 mclk_in = ~mclk_in;

  emb_bus emb_bus_inst (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .ext_access_select_in(strap),
    .req_in(req), .power_control_register_we_in(power_control_register_we), .power_control_register_wdata_in(power_control_register_wdata),
    .instr_out(instr), .instr_valid_out(instr_valid), .rdata_out(rdata),
    .xmove_done_out(xdone), .ale_quiet_enable_out(quiet), .ea_internal_out(ea_int),
    .p0_in(p0_level), .pins_out(pins));

  emb_ext_mem emb_ext_mem_inst (
    .mclk_in(mclk_in), .pins_in(pins), .p0_level_out(p0_level),
    .wr_addr_out(wr_addr), .wr_data_out(wr_data));

  // pin activity counters; the history lets a data cycle be judged after it ends
  always @(posedge mclk_in) begin
    if (pins.ale && !ale_q) ale_rises++;
    if (!pins.program_fetch_strobe_n_n && program_fetch_strobe_n_q) program_fetch_strobe_n_falls++;
    if (!pins.rd_n) rd_lows++;
    if (!pins.wr_n) wr_lows++;
    if (pins.ale) ale_highs++;
    if (instr_valid) valids++;
    ale_q = pins.ale;
    program_fetch_strobe_n_q = pins.program_fetch_strobe_n_n;
    program_fetch_strobe_n_hist = {program_fetch_strobe_n_hist[10:0], pins.program_fetch_strobe_n_n};
  end

  task automatic close_out();
    if (miscompares == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : cyc

  // cleared off the edge so the monitor never races the clear
  task automatic clr();
    @(negedge mclk_in);
    {ale_rises, program_fetch_strobe_n_falls, rd_lows, wr_lows, ale_highs, valids} = '0;
  endtask : clr

  task automatic measure(input int n);
    clr();
    cyc(n);
    @(negedge mclk_in);
  endtask : measure

  task automatic set_pc(input logic [15:0] pc);
    @(posedge mclk_in);
    req.fetch_en <= 1'b1;
    req.pc       <= pc;
    cyc(24);
  endtask : set_pc

  task automatic do_reset(input logic s);
    @(posedge mclk_in);
    reset_n_in <= 1'b0;
    strap      <= s;
    cyc(8);
    reset_n_in <= 1'b1;
    cyc(2);
    @(negedge mclk_in);
    check(quiet, 1'b0);
    check(ea_int, s);
  endtask : do_reset

  task automatic power_control_register_write(input logic [7:0] v, input logic exp);
    @(posedge mclk_in);
    power_control_register_we    <= 1'b1;
    power_control_register_wdata <= v;
    @(posedge mclk_in);
    power_control_register_we    <= 1'b0;
    @(negedge mclk_in);
    check(quiet, exp);
  endtask : power_control_register_write

  task automatic t_ext_fetch();
    set_pc(16'hC3A5);
    measure(24);
    check(program_fetch_strobe_n_falls, 16'h0004);
    check(ale_rises, 16'h0004);
    check(valids, 16'h0004);
    check(instr, 8'hC3 ^ 8'hA5 ^ 8'h5A);
  endtask : t_ext_fetch

  task automatic t_int_quiet();
    set_pc(16'h0100);
    measure(24);
    check(program_fetch_strobe_n_falls, 16'h0000);
    check(ale_rises, 16'h0004);
    power_control_register_write(8'h20, 1'b1);
    cyc(24);
    measure(24);
    check(ale_highs, 16'h0000);
    power_control_register_write(8'hDF, 1'b0);
    power_control_register_write(8'h20, 1'b1);
    set_pc(16'hC3A5);
    measure(24);
    check(ale_rises, 16'h0004);
    check(program_fetch_strobe_n_falls, 16'h0004);
    set_pc(16'h0100);
  endtask : t_int_quiet

  // data move with quiet set; internal run cycles give no latch pulse of their own
  task automatic t_xmove(input logic ext, input logic wr, input logic [15:0] a,
                         input logic [7:0] d);
    int i;
    clr();
    @(posedge mclk_in);
    req.xmove  <= 1'b1;
    req.xwrite <= wr;
    req.xaddr  <= a;
    req.wdata  <= d;
    // kind is taken at the edge the done pulse rises, so drop the request in the strobe slot
    for (i = 0; i < 40 && pins.rd_n && pins.wr_n; i++) @(negedge mclk_in);
    @(posedge mclk_in);
    req.xmove <= 1'b0;
    for (i = 0; i < 40 && xdone !== 1'b1; i++) @(negedge mclk_in);
    if (xdone !== 1'b1) begin
      miscompares++;
      close_out();
    end
    check(program_fetch_strobe_n_hist[9:2], 8'hFF);
    if (!ext) check(ale_rises, 16'h0001);
    check(rd_lows, wr ? 16'h0000 : 16'h0004);
    check(wr_lows, wr ? 16'h0004 : 16'h0000);
    cyc(2);
    @(negedge mclk_in);
    if (wr) check(wr_addr, a);
    if (wr) check(wr_data, d);
    if (!wr) check(rdata, a[7:0] ^ a[15:8] ^ 8'h5A);
  endtask : t_xmove

  task automatic t_power();
    @(posedge mclk_in);
    req.idle <= 1'b1;
    cyc(24);
    measure(12);
    check(ale_highs, 16'h000C);
    check(program_fetch_strobe_n_falls, 16'h0000);
    @(posedge mclk_in);
    req.pdown <= 1'b1;
    cyc(24);
    measure(12);
    check(ale_highs, 16'h0000);
    @(posedge mclk_in);
    req.idle  <= 1'b0;
    req.pdown <= 1'b0;
    cyc(24);
  endtask : t_power

  task automatic t_ext_mode();
    power_control_register_write(8'h20, 1'b1);
    set_pc(16'h0100);
    measure(24);
    check(program_fetch_strobe_n_falls, 16'h0004);
    check(ale_rises, 16'h0004);
  endtask : t_ext_mode

  initial begin
    do_reset(1'b1);
    t_ext_fetch();
    t_int_quiet();
    t_xmove(1'b0, 1'b0, 16'h4B7E, 8'h00);
    t_xmove(1'b0, 1'b1, 16'h9D21, 8'hE4);
    t_power();
    @(posedge mclk_in);
    strap <= 1'b0;
    cyc(4);
    check(ea_int, 1'b1);
    do_reset(1'b0);
    t_ext_mode();
    t_xmove(1'b1, 1'b0, 16'h1234, 8'h00);
    close_out();
  end
endmodule : external_memory_bus_strobes_tb
